// ==== rtl/aer_pkg.sv ====
// package for the error severity and correctable status register bank
// assumes a single 20 MHz clock and a config-space word access port
package aer_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] SEVERITY_OFFSET   = 12'h10c;
  localparam logic [11:0] CORR_STATUS_OFFSET = 12'h110;

  // ---------------------------------------------------------------
  // severity register layout
  // ---------------------------------------------------------------
  localparam logic [31:0] SEVERITY_RESET    = 32'h0006_2011;
  localparam logic [31:0] SEVERITY_WR_MASK  = 32'h001f_f010;
  localparam logic [31:0] SEVERITY_FORCE1   = 32'h0000_0001;

  // bit positions of the uncorrectable error classes
  localparam int SEV_UNSUPPORTED_REQ = 20;
  localparam int SEV_END_TO_END_CRC  = 19;
  localparam int SEV_MALFORMED       = 18;
  localparam int SEV_RX_OVERFLOW     = 17;
  localparam int SEV_UNEXP_CPL       = 16;
  localparam int SEV_COMPLETER_ABORT = 15;
  localparam int SEV_CPL_TIMEOUT     = 14;
  localparam int SEV_FLOW_CONTROL    = 13;
  localparam int SEV_POISONED        = 12;
  localparam int SEV_LINK_PROTOCOL   = 4;

  // ---------------------------------------------------------------
  // correctable status layout
  // ---------------------------------------------------------------
  localparam logic [31:0] CORR_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CORR_STATUS_MASK  = 32'h0000_11c1;
  localparam int COR_RETRANSMIT_TIMER = 12;
  localparam int COR_REPLAY_ROLLOVER  = 8;
  localparam int COR_LINK_PKT_DECODE  = 7;
  localparam int COR_TRANS_PKT_DECODE = 6;
  localparam int COR_RECEIVER_ERROR   = 0;

  // config-space access from the root complex side
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } aer_cfg_req_t;

  // link and physical layer correctable events, one-cycle pulses
  typedef struct packed {
    logic retransmit_timer_expired;
    logic replay_rollover;
    logic decode_error;
    logic rx_link_packet;
    logic rx_transaction_packet;
  } aer_corr_evt_t;

  typedef enum logic [0:0] {
    AER_NONFATAL = 1'b0,
    AER_FATAL    = 1'b1
  } aer_sev_t;

endpackage : aer_pkg

// ==== rtl/aer_sticky_bit.sv ====
// one hardware-set, write-one-clear status bit
// assumes synchronous active-high reset
module aer_sticky_bit (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      q_ff
);

  logic nxt_q;

  // set wins over a clear in the same cycle
  always_comb begin
    nxt_q = (q_ff & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule // aer_sticky_bit

// ==== rtl/aer_severity_correctable_status.sv ====
// severity register and correctable error status register of the
// advanced error reporting block on the primary link
// assumes rst is the OR of link reset, global reset input and power-on
// reset, already synchronous to clk; one access at a time
//
// Functional notes
// - severity register at 10Ch, correctable status at 110h
// - severity bit 1 means fatal, 0 means nonfatal
// - severity reads 00062011h after reset; its live bits are writable
// - bits 20,19,16,15,14,12 default nonfatal
// - bits 18,17,13,4 default fatal
// - reserved severity bits read zero, bit 0 reads one
// - link, global and power-on reset restore both registers
// - status bits stay set until software writes one to them
// - retransmit timer expiry sets status bit 12
// - replay counter rollover sets status bit 8
// - decode error during link packet sets bit 7
// - decode error during transaction packet sets bit 6
// - any decode error sets bit 0
// - reserved status bits read zero
// - status reads all zero after reset
// - masked errors set no status and send no message
module aer_severity_correctable_status (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // config access
  input  wire aer_pkg::aer_cfg_req_t cfg_req,
  output logic [31:0]                cfg_rdata_ff,
  output logic                       cfg_rvalid_ff,
  // correctable events and their mask
  input  wire aer_pkg::aer_corr_evt_t corr_evt,
  input  wire logic [31:0]           corr_mask,
  // uncorrectable detection and mask
  input  wire logic [31:0]           uncorr_detect,
  input  wire logic [31:0]           uncorr_mask,
  // error message request
  output logic                       msg_valid_ff,
  output aer_pkg::aer_sev_t          msg_type_ff,
  output logic [31:0]                severity_ff
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic sel_sev;
  logic sel_cor;
  logic wr_sev;
  logic wr_cor;

  always_comb begin
    sel_sev = (cfg_req.addr == aer_pkg::SEVERITY_OFFSET);
    sel_cor = (cfg_req.addr == aer_pkg::CORR_STATUS_OFFSET);
    wr_sev  = cfg_req.wr & sel_sev;
    wr_cor  = cfg_req.wr & sel_cor;
  end

  // ---------------------------------------------------------------
  // severity register
  // ---------------------------------------------------------------
  logic [31:0] nxt_severity;

  always_comb begin
    nxt_severity = severity_ff;
    if (wr_sev) begin
      nxt_severity = (cfg_req.wdata & aer_pkg::SEVERITY_WR_MASK)
                   | aer_pkg::SEVERITY_FORCE1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      severity_ff <= aer_pkg::SEVERITY_RESET;
    end else begin
      severity_ff <= nxt_severity;
    end
  end

  // ---------------------------------------------------------------
  // correctable status bits
  // ---------------------------------------------------------------
  logic [31:0] cor_set;
  logic [31:0] cor_clr;
  logic [31:0] cor_q;
  logic [31:0] cor_status;

  always_comb begin
    cor_set = '0;
    cor_set[aer_pkg::COR_RETRANSMIT_TIMER] = corr_evt.retransmit_timer_expired;
    cor_set[aer_pkg::COR_REPLAY_ROLLOVER]  = corr_evt.replay_rollover;
    cor_set[aer_pkg::COR_LINK_PKT_DECODE]  =
      corr_evt.decode_error & corr_evt.rx_link_packet;
    cor_set[aer_pkg::COR_TRANS_PKT_DECODE] =
      corr_evt.decode_error & corr_evt.rx_transaction_packet;
    cor_set[aer_pkg::COR_RECEIVER_ERROR]   = corr_evt.decode_error;
    cor_set = cor_set & ~corr_mask & aer_pkg::CORR_STATUS_MASK;
    cor_clr = wr_cor ? cfg_req.wdata : '0;
  end

  // only the implemented positions get a flop
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cor
      if (aer_pkg::CORR_STATUS_MASK[gi]) begin : g_bit
        aer_sticky_bit u_bit (
          .clk  (clk),
          .rst  (rst),
          .set  (cor_set[gi]),
          .clr  (cor_clr[gi]),
          .q_ff (cor_q[gi])
        );
      end else begin : g_rsvd
        assign cor_q[gi] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    cor_status = cor_q & aer_pkg::CORR_STATUS_MASK;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata_ff  <= '0;
      cfg_rvalid_ff <= 1'b0;
    end else begin
      cfg_rvalid_ff <= cfg_req.rd;
      if (cfg_req.rd && sel_sev) begin
        cfg_rdata_ff <= severity_ff;
      end else if (cfg_req.rd && sel_cor) begin
        cfg_rdata_ff <= cor_status;
      end else if (cfg_req.rd) begin
        cfg_rdata_ff <= '0; // unmapped offsets read zero
      end
    end
  end

  // ---------------------------------------------------------------
  // uncorrectable message type
  // ---------------------------------------------------------------
  // fatal wins when several classes hit together: the stronger message
  // covers both, and the link sends only one per event
  logic [31:0] live_uncorr;
  logic        any_fatal;

  always_comb begin
    live_uncorr = uncorr_detect & ~uncorr_mask & aer_pkg::SEVERITY_WR_MASK;
    any_fatal   = |(live_uncorr & severity_ff);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      msg_valid_ff <= 1'b0;
      msg_type_ff  <= aer_pkg::AER_NONFATAL;
    end else begin
      msg_valid_ff <= |live_uncorr;
      msg_type_ff  <= any_fatal ? aer_pkg::AER_FATAL : aer_pkg::AER_NONFATAL;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sev_write;
    cfg_req.wr && sel_sev;
  endsequence

  sev_write_a: assert property (s_sev_write |=> severity_ff ==
    (($past(cfg_req.wdata) & aer_pkg::SEVERITY_WR_MASK) | 32'h0000_0001))
    else $error("severity write not stored");

  sev_rsvd_a: assert property (severity_ff[0] && severity_ff[31:21] == '0
    && severity_ff[11:5] == '0 && severity_ff[3:1] == '0)
    else $error("severity reserved bits wrong");

  reset_val_a: assert property (@(posedge clk) disable iff (1'b0)
    $past(rst) |-> severity_ff == 32'h0006_2011 && cor_status == '0)
    else $error("reset values wrong");

  sticky_hold_a: assert property (cor_status[0] && !(wr_cor && cfg_req.wdata[0])
    |=> cor_status[0])
    else $error("status bit dropped without clear");

  w1c_clear_a: assert property (wr_cor && cfg_req.wdata[12] && !cor_set[12]
    |=> !cor_status[12])
    else $error("write one did not clear");

  timer_set_a: assert property (corr_evt.retransmit_timer_expired && !corr_mask[12]
    |=> cor_status[12])
    else $error("timer expiry not recorded");

  roll_set_a: assert property (corr_evt.replay_rollover && !corr_mask[8]
    |=> cor_status[8])
    else $error("rollover not recorded");

  dllp_set_a: assert property (corr_evt.decode_error && corr_evt.rx_link_packet
    && !corr_mask[7] |=> cor_status[7])
    else $error("link packet decode error not recorded");

  tlp_set_a: assert property (corr_evt.decode_error && corr_evt.rx_transaction_packet
    && !corr_mask[6] |=> cor_status[6])
    else $error("transaction packet decode error not recorded");

  rx_err_set_a: assert property (corr_evt.decode_error && !corr_mask[0]
    |=> cor_status[0])
    else $error("receiver error not recorded");

  cor_rsvd_a: assert property ((cor_status & ~32'h0000_11c1) == '0)
    else $error("status reserved bits set");

  masked_a: assert property (!cor_status[8] && corr_mask[8] && corr_evt.replay_rollover
    |=> !cor_status[8])
    else $error("masked event set status");

  msg_type_a: assert property (|live_uncorr |=> msg_valid_ff
    && (msg_type_ff == aer_pkg::AER_FATAL) == $past(any_fatal))
    else $error("message type does not follow severity");

  set_wins_a: assert property (cor_set[12] && wr_cor && cfg_req.wdata[12]
    |=> cor_status[12])
    else $error("event lost under clear");

endmodule // aer_severity_correctable_status

// ==== tb/aer_rc_model.sv ====
// root complex side model: issues config reads and writes
// assumes the bank answers a read exactly one cycle after it is taken
module aer_rc_model (
  // clock
  input  wire logic             clk,
  // config access
  output aer_pkg::aer_cfg_req_t cfg_req,
  input  wire logic [31:0]      cfg_rdata_ff,
  input  wire logic             cfg_rvalid_ff
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial cfg_req = '0;

  // software clears a status bit only by writing one to it
  task automatic cfg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    cfg_req.wr <= 1'b0;
  endtask

  task automatic cfg_read(input logic [11:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    cfg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    cfg_req.rd <= 1'b0;
    // answer stands one cycle only, so look just after the taking edge
    #1;
    v = cfg_rvalid_ff;
    d = cfg_rdata_ff;
  endtask
endmodule // aer_rc_model

// ==== tb/aer_severity_correctable_status_tb.sv ====
// self-checking bench for the severity and correctable status bank
// assumes the root complex model drives all config traffic
module aer_severity_correctable_status_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                   clk;
  logic                   rst;
  aer_pkg::aer_cfg_req_t  cfg_req;
  aer_pkg::aer_corr_evt_t corr_evt;
  aer_pkg::aer_corr_evt_t e;
  aer_pkg::aer_sev_t      msg_type_ff;
  logic [31:0]            corr_mask, uncorr_detect, uncorr_mask, cfg_rdata_ff, severity_ff;
  logic [31:0]            sev, st, w, m;
  logic                   cfg_rvalid_ff, msg_valid_ff;
  int                     n_mismatch = 0, compares = 0, cyc = 0, p;
  int                     seed = 32'hb53b64c8;
  int                     pos [10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
  localparam logic [11:0] SEV = 12'h10c;
  localparam logic [11:0] COR = 12'h110;

  aer_severity_correctable_status dut (.clk(clk), .rst(rst), .cfg_req(cfg_req),
    .cfg_rdata_ff(cfg_rdata_ff), .cfg_rvalid_ff(cfg_rvalid_ff), .corr_evt(corr_evt),
    .corr_mask(corr_mask), .uncorr_detect(uncorr_detect), .uncorr_mask(uncorr_mask),
    .msg_valid_ff(msg_valid_ff), .msg_type_ff(msg_type_ff), .severity_ff(severity_ff));
  aer_rc_model rc (.clk(clk), .cfg_req(cfg_req), .cfg_rdata_ff(cfg_rdata_ff),
    .cfg_rvalid_ff(cfg_rvalid_ff));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic        v;
    rc.cfg_read(a, d, v);
    chk("cfg_rvalid", 32'h1, {31'h0, v});
    chk("cfg_rdata", x, d);
  endtask

  // status bits an event should set, before masking
  function automatic logic [31:0] ev_bits(input aer_pkg::aer_corr_evt_t ev);
    ev_bits = 32'h0;
    ev_bits[12] = ev.retransmit_timer_expired;
    ev_bits[8] = ev.replay_rollover;
    ev_bits[7] = ev.decode_error & ev.rx_link_packet;
    ev_bits[6] = ev.decode_error & ev.rx_transaction_packet;
    ev_bits[0] = ev.decode_error;
  endfunction

  task automatic pulse_unc(input int b, input logic [31:0] mk);
    @(posedge clk);
    uncorr_detect <= 32'h1 << b;
    uncorr_mask <= mk;
    @(posedge clk);
    uncorr_detect <= '0;
    #1;
    chk("msg_valid", {31'h0, ~mk[b]}, {31'h0, msg_valid_ff});
    if (!mk[b]) chk("msg_type", {31'h0, sev[b]}, {31'h0, msg_type_ff});
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    corr_evt = '0;
    corr_mask = '0;
    uncorr_detect = '0;
    uncorr_mask = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    st = 32'h0;
    rd(SEV, 32'h0006_2011);
    rd(COR, 32'h0);
    rc.cfg_write(12'h114, 32'hffff_ffff);
    rd(12'h114, 32'h0);
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
      rc.cfg_write(SEV, w);
      sev = (w & 32'h001f_f010) | 32'h1;
      rd(SEV, sev);
      chk("severity_ff", sev, severity_ff);
      p = pos[$unsigned($random(seed)) % 10];
      pulse_unc(p, (i % 3 == 2) ? 32'hffff_ffff : 32'h0);
    end
    for (int i = 0; i < 24; i++) begin
      e = 5'($random(seed));
      m = $random(seed) & $random(seed);
      @(posedge clk);
      corr_evt <= e;
      corr_mask <= m;
      @(posedge clk);
      corr_evt <= '0;
      st = st | (ev_bits(e) & ~m);
      rd(COR, st);
      w = $random(seed) & $random(seed);
      rc.cfg_write(COR, w);
      st = st & ~w;
    end
    // clear-all racing a rollover event on the same edge
    fork
      rc.cfg_write(COR, 32'hffff_ffff);
      begin
        @(posedge clk);
        corr_evt <= 5'h08;
        corr_mask <= 32'h0;
        @(posedge clk);
        corr_evt <= '0;
      end
    join
    rd(COR, 32'h100);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(SEV, 32'h0006_2011);
    rd(COR, 32'h0);
    stop_test();
  end
endmodule // aer_severity_correctable_status_tb
